/* File: hw/accel_rate_cfg.sv */
`timescale 1ns/1ps
`include "accel_cfg_defs.svh"
// Overview of operation
// (RULE_01) The device comes out of power-up in low-noise mode, not duty-cycled.
// (RULE_02) Three read/write bytes hold the factory self-test code per axis.
// (RULE_03) Host converts the stored code to LSB from full scale and code.
// (RULE_04) Output rate equals internal rate divided by one plus the divider.
// (RULE_05) The internal rate that the divider divides is 1 kHz.
// (RULE_06) Divider acts only with bypass bits zero and filter setting 1 to 6.
// (RULE_07) The divided strobe paces output register updates and FIFO writes.
// (RULE_08) With the policy bit set and FIFO full, new samples are dropped.
// (RULE_09) With the policy bit clear and FIFO full, the oldest is overwritten.
// (RULE_10) Sync select puts the sync value in temp, X, Y or Z low bit 0.
// (RULE_11) Sync input is latched on a toggle and locked until the strobe captures.
// (RULE_12) Low-pass filter is used only when both bypass bits are zero.
// (RULE_13) Temperature bandwidth is 4000 Hz or 188 to 5 Hz per setting.
// (RULE_14) Without an effective divider, updates run at the full path rate.
// (RULE_15) Registers reset to zero; self-test bytes keep their factory values.
module accel_rate_cfg #(
   parameter logic [7:0] FACTORY_ST_X = 8'h00,
   parameter logic [7:0] FACTORY_ST_Y = 8'h00,
   parameter logic [7:0] FACTORY_ST_Z = 8'h00,
   parameter int SLOW_CYC = `INT_RATE_CYC,
   parameter int FAST_CYC = `BYPASS_RATE_CYC
) (
   input logic core_clk,
   input logic rst_n,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   input logic [1:0] filter_bypass_bits,
   input logic frame_sync_input,
   input logic fifo_full,
   output logic low_noise_mode_q,
   output logic output_update_q,
   output logic fifo_write_q,
   output logic fifo_discard_oldest_q,
   output logic temp_sync_bit_q,
   output logic x_sync_bit_q,
   output logic y_sync_bit_q,
   output logic z_sync_bit_q,
   output logic lowpass_enable_q,
   output logic [2:0] lowpass_setting_q,
   output logic [11:0] temp_bandwidth_hz_q
);
   logic rst_meta_q;
   logic rst_sync_n;
   logic [7:0] x_factory_selftest_code;
   logic [7:0] y_factory_selftest_code;
   logic [7:0] z_factory_selftest_code;
   logic [7:0] rate_divider_value;
   logic [7:0] path_cfg_q;
   logic sync_meta_q;
   logic sync_pin_q;
   logic sync_seen_q;
   logic frame_sync_input_latched_q;
   logic frame_sync_input_armed_q;
   logic sync_edge;
   logic strobe;
   logic fifo_mode;
   logic [2:0] lowpass_setting;
   accel_cfg_pkg::sync_loc_t frame_sync_select;
   rate_if rate ();

   function automatic logic [11:0] temp_bw(input logic [1:0] byp, input logic [2:0] cfg);
      logic [11:0] bw;
      bw = `TBW_WIDE;
      if (byp == 2'b00) begin
         unique case (cfg)
            3'd1: bw = `TBW_S1;
            3'd2: bw = `TBW_S2;
            3'd3: bw = `TBW_S3;
            3'd4: bw = `TBW_S4;
            3'd5: bw = `TBW_S5;
            3'd6: bw = `TBW_S6;
            3'd0, 3'd7: bw = `TBW_WIDE;
         endcase
      end
      return bw;
   endfunction : temp_bw

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   assign fifo_mode = path_cfg_q[`CFG_FIFO_MODE_BIT];
   assign lowpass_setting = path_cfg_q[`CFG_LPF_MSB:`CFG_LPF_LSB];
   assign frame_sync_select =
      accel_cfg_pkg::sync_loc_t'(path_cfg_q[`CFG_SYNC_MSB:`CFG_SYNC_LSB]);
   assign strobe = rate.sample_strobe;
   assign rate.fast_path = (filter_bypass_bits != 2'b00);
   assign rate.divider = rate_divider_value;
   assign rate.divide_en = (filter_bypass_bits == 2'b00) && (lowpass_setting != 3'd0)
      && (lowpass_setting != 3'd7); // RULE_06

   rate_strobe_gen #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) i_rate_strobe_gen (
      .core_clk(core_clk),
      .rst_sync_n(rst_sync_n),
      .rate(rate.gen)
   );

   // Register writes; bit 7 of the path register is held at zero.
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         x_factory_selftest_code <= FACTORY_ST_X; // RULE_15
         y_factory_selftest_code <= FACTORY_ST_Y;
         z_factory_selftest_code <= FACTORY_ST_Z;
         rate_divider_value <= `RST_RATE_DIV;
         path_cfg_q <= `RST_PATH_CFG;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `ADDR_ST_X: x_factory_selftest_code <= reg_wdata; // RULE_02
            `ADDR_ST_Y: y_factory_selftest_code <= reg_wdata;
            `ADDR_ST_Z: z_factory_selftest_code <= reg_wdata;
            `ADDR_RATE_DIV: rate_divider_value <= reg_wdata;
            `ADDR_PATH_CFG: path_cfg_q <= {1'b0, reg_wdata[6:0]};
            default: ;
         endcase
      end
   end

   // Unmapped addresses read as zero.
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata_q <= `RST_BYTE;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `ADDR_ST_X: reg_rdata_q <= x_factory_selftest_code; // RULE_02
            `ADDR_ST_Y: reg_rdata_q <= y_factory_selftest_code;
            `ADDR_ST_Z: reg_rdata_q <= z_factory_selftest_code;
            `ADDR_RATE_DIV: reg_rdata_q <= rate_divider_value;
            `ADDR_PATH_CFG: reg_rdata_q <= path_cfg_q;
            default: reg_rdata_q <= `RST_BYTE;
         endcase
      end
   end

   // Nothing here can leave low-noise mode, so the flag only reports it.
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         low_noise_mode_q <= 1'b1; // RULE_01
      end else begin
         low_noise_mode_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sync_meta_q <= 1'b0;
         sync_pin_q <= 1'b0;
         sync_seen_q <= 1'b0;
      end else begin
         sync_meta_q <= frame_sync_input;
         sync_pin_q <= sync_meta_q;
         sync_seen_q <= sync_pin_q;
      end
   end

   assign sync_edge = sync_pin_q != sync_seen_q;

   // A toggle locks the latch so that a short pulse survives until sampled.
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         frame_sync_input_latched_q <= 1'b0;
         frame_sync_input_armed_q <= 1'b1;
      end else if (sync_edge && frame_sync_input_armed_q) begin
         frame_sync_input_latched_q <= ~frame_sync_input_latched_q; // RULE_11
         frame_sync_input_armed_q <= 1'b0;
      end else if (strobe) begin
         frame_sync_input_armed_q <= 1'b1; // RULE_11
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         temp_sync_bit_q <= 1'b0;
         x_sync_bit_q <= 1'b0;
         y_sync_bit_q <= 1'b0;
         z_sync_bit_q <= 1'b0;
      end else if (strobe) begin
         temp_sync_bit_q <= (frame_sync_select == accel_cfg_pkg::SYNC_TEMP) && frame_sync_input_latched_q; // RULE_10
         x_sync_bit_q <= (frame_sync_select == accel_cfg_pkg::SYNC_X) && frame_sync_input_latched_q;
         y_sync_bit_q <= (frame_sync_select == accel_cfg_pkg::SYNC_Y) && frame_sync_input_latched_q;
         z_sync_bit_q <= (frame_sync_select == accel_cfg_pkg::SYNC_Z) && frame_sync_input_latched_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         output_update_q <= 1'b0;
         fifo_write_q <= 1'b0;
         fifo_discard_oldest_q <= 1'b0;
      end else begin
         output_update_q <= strobe; // RULE_07
         fifo_write_q <= strobe && !(fifo_full && fifo_mode); // RULE_07 RULE_08
         fifo_discard_oldest_q <= strobe && fifo_full && !fifo_mode; // RULE_09
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         lowpass_enable_q <= 1'b0;
         lowpass_setting_q <= 3'h0;
         temp_bandwidth_hz_q <= `TBW_WIDE;
      end else begin
         lowpass_enable_q <= (filter_bypass_bits == 2'b00); // RULE_12
         lowpass_setting_q <= lowpass_setting;
         temp_bandwidth_hz_q <= temp_bw(filter_bypass_bits, lowpass_setting); // RULE_13
      end
   end

   default clocking dflt @(posedge core_clk);
   endclocking
   default disable iff (!rst_sync_n);

   a_low_noise_on: assert property (low_noise_mode_q) // RULE_01
      else $error("Low-noise mode flag dropped.");
   a_divider_gate: assert property (rate.divide_en |->
      (filter_bypass_bits == 2'b00 && lowpass_setting inside {[3'd1:3'd6]})) // RULE_06
      else $error("Divider active outside its legal filter settings.");
   a_update_follows: assert property (strobe |=> output_update_q ##1 !output_update_q) // RULE_07
      else $error("Output update did not follow the strobe.");
   a_fifo_drop: assert property (strobe && fifo_full && fifo_mode |=> !fifo_write_q) // RULE_08
      else $error("Sample written into a full FIFO in drop mode.");
   a_fifo_overwrite: assert property (strobe && fifo_full && !fifo_mode
      |=> fifo_write_q && fifo_discard_oldest_q) // RULE_09
      else $error("Full FIFO not overwritten in replace mode.");
   a_sync_place: assert property (strobe && frame_sync_select == accel_cfg_pkg::SYNC_Y
      |=> y_sync_bit_q == $past(frame_sync_input_latched_q) && !x_sync_bit_q && !temp_sync_bit_q) // RULE_10
      else $error("Sync bit placed in the wrong output.");
   a_sync_reserved: assert property (strobe && frame_sync_select inside {[3'd2:3'd4]}
      |=> !(temp_sync_bit_q || x_sync_bit_q || y_sync_bit_q || z_sync_bit_q)) // RULE_10
      else $error("Reserved sync select placed a bit.");
   a_latch_locked: assert property (!frame_sync_input_armed_q && !strobe |=> $stable(frame_sync_input_latched_q)) // RULE_11
      else $error("Latched sync toggled twice before capture.");
   a_lpf_enable: assert property (filter_bypass_bits != 2'b00 |=> !lowpass_enable_q) // RULE_12
      else $error("Low-pass enabled while bypassed.");
   a_temp_bw: assert property (filter_bypass_bits == 2'b00 && lowpass_setting == 3'd3
      |=> temp_bandwidth_hz_q == `TBW_S3) // RULE_13
      else $error("Temperature bandwidth wrong for setting 3.");
   a_reset_clear: assert property ($rose(rst_sync_n) |->
      rate_divider_value == 8'h00 && path_cfg_q == 8'h00) // RULE_15
      else $error("Configuration not zero after reset.");

   c_divided: cover property (rate.divide_en && rate_divider_value != 8'h00 ##1 strobe);
   c_drop: cover property (strobe && fifo_full && fifo_mode);
   c_sync_z: cover property (strobe && frame_sync_select == accel_cfg_pkg::SYNC_Z
      && frame_sync_input_latched_q);
endmodule : accel_rate_cfg

/* File: hw/accel_cfg_defs.svh */
`ifndef ACCEL_CFG_DEFS_SVH
`define ACCEL_CFG_DEFS_SVH

// Register offsets on the internal register port.
`define ADDR_ST_X 8'h0d
`define ADDR_ST_Y 8'h0e
`define ADDR_ST_Z 8'h0f
`define ADDR_RATE_DIV 8'h19
`define ADDR_PATH_CFG 8'h1a

// Reset values.
`define RST_RATE_DIV 8'h00
`define RST_PATH_CFG 8'h00
`define RST_BYTE 8'h00

// Field positions of the path configuration register.
`define CFG_ZERO_BIT 7
`define CFG_FIFO_MODE_BIT 6
`define CFG_SYNC_MSB 5
`define CFG_SYNC_LSB 3
`define CFG_LPF_MSB 2
`define CFG_LPF_LSB 0

// Timing.
`define CORE_CLK_HZ 100000000
`define INT_RATE_HZ 1000
`define BYPASS_RATE_HZ 4000
`define INT_RATE_CYC (`CORE_CLK_HZ / `INT_RATE_HZ)
`define BYPASS_RATE_CYC (`CORE_CLK_HZ / `BYPASS_RATE_HZ)

// Temperature path bandwidth figures in Hz.
`define TBW_WIDE 12'd4000
`define TBW_S1 12'd188
`define TBW_S2 12'd98
`define TBW_S3 12'd42
`define TBW_S4 12'd20
`define TBW_S5 12'd10
`define TBW_S6 12'd5

`endif

/* File: hw/accel_cfg_pkg.sv */
package accel_cfg_pkg;
   typedef enum logic [2:0] {
      SYNC_OFF = 3'b000,
      SYNC_TEMP = 3'b001,
      SYNC_RSV2 = 3'b010,
      SYNC_RSV3 = 3'b011,
      SYNC_RSV4 = 3'b100,
      SYNC_X = 3'b101,
      SYNC_Y = 3'b110,
      SYNC_Z = 3'b111
   } sync_loc_t;
   typedef logic [7:0] reg_byte_t;
endpackage : accel_cfg_pkg

/* File: hw/rate_if.sv */
`timescale 1ns/1ps
interface rate_if;
   logic fast_path;
   logic divide_en;
   accel_cfg_pkg::reg_byte_t divider;
   logic sample_strobe;
   modport gen (input fast_path, input divide_en, input divider, output sample_strobe);
   modport cfg (output fast_path, output divide_en, output divider, input sample_strobe);
endinterface : rate_if

/* File: hw/rate_strobe_gen.sv */
`timescale 1ns/1ps
`include "accel_cfg_defs.svh"
module rate_strobe_gen #(
   parameter int SLOW_CYC = `INT_RATE_CYC,
   parameter int FAST_CYC = `BYPASS_RATE_CYC
) (
   input logic core_clk,
   input logic rst_sync_n,
   rate_if.gen rate
);
   logic [16:0] base_cnt_q;
   logic [7:0] div_cnt_q;
   logic strobe_q;
   logic [16:0] last_cnt;
   logic base_tick;
   logic div_done;

   assign last_cnt = rate.fast_path ? 17'(FAST_CYC - 1) : 17'(SLOW_CYC - 1);
   assign base_tick = (base_cnt_q >= last_cnt);
   assign div_done = !rate.divide_en || (div_cnt_q >= rate.divider);
   assign rate.sample_strobe = strobe_q;

   // Base tick at 1 kHz on the filtered path, at the wide rate when bypassed.
   always_ff @(posedge core_clk or negedge rst_sync_n) begin // RULE_05
      if (!rst_sync_n) begin
         base_cnt_q <= 17'h00000;
      end else if (base_tick) begin
         base_cnt_q <= 17'h00000;
      end else begin
         base_cnt_q <= base_cnt_q + 17'h00001;
      end
   end

   // One strobe every divider+1 base ticks; undivided when the divider is off.
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         div_cnt_q <= 8'h00;
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= base_tick && div_done; // RULE_04 RULE_14
         if (base_tick) begin
            div_cnt_q <= div_done ? 8'h00 : div_cnt_q + 8'h01;
         end
      end
   end

   a_strobe_single: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      strobe_q |=> !strobe_q) // RULE_04
      else $error("Sample strobe lasted more than one cycle.");
   a_undivided_tick: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      base_tick && !rate.divide_en |=> strobe_q) // RULE_14
      else $error("Base tick without an effective divider gave no strobe.");
   a_divided_skip: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      base_tick && rate.divide_en && div_cnt_q < rate.divider |=> !strobe_q) // RULE_04
      else $error("Strobe raised before the divider count ran out.");
endmodule : rate_strobe_gen

/* File: bench/fifo_occ_model.sv */
`timescale 1ns/1ps
module fifo_occ_model #(
   parameter int DEPTH = 4
) (
   input logic core_clk,
   input logic rst_n,
   input logic push,
   input logic drop_oldest,
   input logic drain,
   output logic fifo_full
);
   int level_q;
   // An overwrite keeps the level at depth, so full never clears without a drain.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         level_q <= 0;
      end else if (drain) begin
         level_q <= 0;
      end else if (push && !drop_oldest && level_q < DEPTH) begin
         level_q <= level_q + 1;
      end
   end
   assign fifo_full = (level_q == DEPTH);
endmodule : fifo_occ_model

/* File: bench/accel_sample_rate_filter_config_tb_top.sv */
`timescale 1ns/1ps
module accel_sample_rate_filter_config_tb_top;
   // Factory codes are arbitrary test values.
   localparam logic [7:0] ST_X = 8'h5a;
   localparam logic [7:0] ST_Y = 8'h3c;
   localparam logic [7:0] ST_Z = 8'h81;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [1:0] filter_bypass_bits = 2'h0;
   logic frame_sync_input = 1'b0;
   logic drain = 1'b1;
   logic fifo_full, low_noise_mode_q, output_update_q, fifo_write_q, fifo_discard_oldest_q;
   logic temp_sync_bit_q, x_sync_bit_q, y_sync_bit_q, z_sync_bit_q, lowpass_enable_q;
   logic [7:0] reg_rdata_q;
   logic [7:0] rd_v;
   logic [7:0] wd;
   logic [2:0] lowpass_setting_q;
   logic [11:0] temp_bandwidth_hz_q;
   logic lat;
   int err_total = 0;
   int n_tests = 0;
   int n;
   logic [7:0] addr_t [6] = '{8'h0d, 8'h0e, 8'h0f, 8'h19, 8'h1a, 8'h20};
   logic [7:0] rst_t [6] = '{ST_X, ST_Y, ST_Z, 8'h00, 8'h00, 8'h00};
   logic [11:0] bw_t [8] = '{12'd4000, 12'd188, 12'd98, 12'd42, 12'd20, 12'd10, 12'd5, 12'd4000};
   logic [1:0] bp_t [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
   logic [2:0] lp_t [6] = '{3'h3, 3'h6, 3'h1, 3'h0, 3'h7, 3'h3};
   logic [7:0] dv_t [6] = '{8'h02, 8'hff, 8'h00, 8'h02, 8'h02, 8'h02};
   int per_t [6] = '{60, 5120, 20, 20, 20, 5};
   // Even entries see the latch at one, so every placing select is shown a set bit.
   logic [2:0] sel_t [9] = '{3'h1, 3'h3, 3'h5, 3'h4, 3'h6, 3'h0, 3'h7, 3'h0, 3'h2};

   always #5 core_clk = ~core_clk;

   accel_rate_cfg #(.FACTORY_ST_X(ST_X), .FACTORY_ST_Y(ST_Y), .FACTORY_ST_Z(ST_Z),
      .SLOW_CYC(20), .FAST_CYC(5)) i_accel_rate_cfg (.core_clk(core_clk), .rst_n(rst_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q), .filter_bypass_bits(filter_bypass_bits),
      .frame_sync_input(frame_sync_input), .fifo_full(fifo_full),
      .low_noise_mode_q(low_noise_mode_q), .output_update_q(output_update_q),
      .fifo_write_q(fifo_write_q), .fifo_discard_oldest_q(fifo_discard_oldest_q),
      .temp_sync_bit_q(temp_sync_bit_q), .x_sync_bit_q(x_sync_bit_q),
      .y_sync_bit_q(y_sync_bit_q), .z_sync_bit_q(z_sync_bit_q),
      .lowpass_enable_q(lowpass_enable_q), .lowpass_setting_q(lowpass_setting_q),
      .temp_bandwidth_hz_q(temp_bandwidth_hz_q));

   fifo_occ_model #(.DEPTH(4)) i_fifo_occ_model (.core_clk(core_clk), .rst_n(rst_n),
      .push(fifo_write_q), .drop_oldest(fifo_discard_oldest_q), .drain(drain),
      .fifo_full(fifo_full));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      d = reg_rdata_q;
   endtask : rd

   // Counts cycles up to the next update pulse; the cap keeps a dead strobe from hanging.
   task automatic wait_strobe(output int cnt);
      cnt = 0;
      do begin
         @(negedge core_clk);
         cnt++;
      end while (output_update_q !== 1'b1 && cnt < 6000);
   endtask : wait_strobe

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      chk(low_noise_mode_q, 1'b1, "low noise");
      for (int i = 0; i < 6; i++) begin
         rd(addr_t[i], rd_v);
         chk(rd_v, rst_t[i], "reset value");
      end
      for (int i = 0; i < 6; i++) begin
         wr(addr_t[i], 8'h81 + 8'h10 * i[7:0]);
      end
      for (int i = 0; i < 6; i++) begin
         wd = (i > 4) ? 8'h00 : (8'h81 + 8'h10 * i[7:0]) & (i == 4 ? 8'h7f : 8'hff);
         rd(addr_t[i], rd_v);
         chk(rd_v, wd, "readback");
      end
      $display("test registers done");
      for (int b = 0; b < 4; b++) begin
         for (int s = 0; s < 8; s++) begin
            filter_bypass_bits = b[1:0];
            wr(8'h1a, {5'h00, s[2:0]});
            repeat (2) @(negedge core_clk);
            chk(temp_bandwidth_hz_q, b == 0 ? bw_t[s] : 12'd4000, "bandwidth");
            chk({lowpass_enable_q, lowpass_setting_q}, {b == 0, s[2:0]}, "lowpass");
         end
      end
      $display("test filter done");
      for (int i = 0; i < 6; i++) begin
         filter_bypass_bits = bp_t[i];
         wr(8'h19, dv_t[i]);
         wr(8'h1a, {5'h00, lp_t[i]});
         wait_strobe(n);
         wait_strobe(n);
         wait_strobe(n);
         chk(n[15:0], per_t[i][15:0], "period");
         chk({fifo_write_q, fifo_discard_oldest_q}, 2'b10, "fifo push");
      end
      $display("test rate done");
      filter_bypass_bits = 2'h0;
      wr(8'h1a, 8'h40);
      drain = 1'b0;
      repeat (6) wait_strobe(n);
      chk({output_update_q, fifo_write_q}, 2'b10, "drop new");
      wr(8'h1a, 8'h00);
      wait_strobe(n);
      wait_strobe(n);
      chk({fifo_write_q, fifo_discard_oldest_q}, 2'b11, "overwrite");
      drain = 1'b1;
      $display("test fifo policy done");
      lat = 1'b0;
      for (int i = 0; i < 9; i++) begin
         wr(8'h1a, {2'b00, sel_t[i], 3'b000});
         wait_strobe(n);
         frame_sync_input = 1'b1;
         repeat (2) @(negedge core_clk);
         // The falling edge lands while the latch is locked, so one pulse flips it once.
         frame_sync_input = 1'b0;
         lat = ~lat;
         repeat (2) wait_strobe(n);
         chk({temp_sync_bit_q, x_sync_bit_q, y_sync_bit_q, z_sync_bit_q},
            {sel_t[i] == 3'h1 && lat, sel_t[i] == 3'h5 && lat,
             sel_t[i] == 3'h6 && lat, sel_t[i] == 3'h7 && lat}, "sync");
      end
      $display("test frame sync done");
      rst_n = 1'b0;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < 6; i++) begin
         rd(addr_t[i], rd_v);
         chk(rd_v, rst_t[i], "value after reset");
      end
      chk(low_noise_mode_q, 1'b1, "low noise after reset");
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule : accel_sample_rate_filter_config_tb_top
